// ==== logic/rcs_pkg.sv ====
package rcs_pkg;

   // Clock and millisecond time base
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_PERIOD_NS  = 1000000;
   localparam int unsigned MS_CYCLES     = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MS_PER_TENTH  = 100;

   // Terminal function codes
   localparam logic [7:0] FUNC_RUN_ENABLE = 8'h0D;
   localparam logic [7:0] FUNC_THREE_WIRE = 8'h0E;

   // Mode parameter encodings
   localparam logic [2:0] CTRL_MODE_VF      = 3'h0;
   localparam logic       GATING_ALWAYS     = 1'b0;
   localparam logic       GATING_BY_INPUT   = 1'b1;
   localparam logic [1:0] STOP_COAST        = 2'h0;
   localparam logic [1:0] STOP_TIMED        = 2'h1;
   localparam logic [1:0] STOP_TIMED_RESUME = 2'h2;

   // Ramp profile selection handed to the ramp generator
   localparam logic [1:0] RAMP_ACC   = 2'h0;
   localparam logic [1:0] RAMP_DEC   = 2'h1;
   localparam logic [1:0] RAMP_QSTOP = 2'h2;

   // Parameter limits and defaults (frequency in 0.01 Hz, time in 0.1 s)
   localparam logic [15:0] DWELL_FREQ_DEFAULT = 16'h01F4;
   localparam logic [9:0]  DWELL_TIME_DEFAULT = 10'h000;
   localparam logic [9:0]  DWELL_TIME_MAX     = 10'h258;
   localparam logic [12:0] QSTOP_TIME_DEFAULT = 13'h0032;
   localparam logic [12:0] QSTOP_TIME_MAX     = 13'h1770;

   // Reset values
   localparam logic [16:0] TICK_CNT_RESET = 17'h00000;
   localparam logic [19:0] TIMER_RESET    = 20'h00000;

   typedef struct packed {
      logic [7:0]  input_terminal_function;
      logic [7:0]  enable_terminal_function;
      logic [2:0]  control_mode_param;
      logic        gating_mode_param;
      logic [1:0]  stop_mode_param;
      logic [12:0] decel_time_param;
      logic [15:0] acc_dwell_freq;
      logic [9:0]  acc_dwell_time;
      logic [15:0] dec_dwell_freq;
      logic [9:0]  dec_dwell_time;
      logic [15:0] start_freq;
      logic [15:0] max_freq;
      logic [15:0] target_freq;
   } rcs_cfg_type;

   typedef enum logic [9:0] {
      ST_IDLE     = 10'h001,
      ST_ACC_RAMP = 10'h002,
      ST_ACC_HOLD = 10'h004,
      ST_RUN      = 10'h008,
      ST_DEC_RAMP = 10'h010,
      ST_DEC_HOLD = 10'h020,
      ST_DEC_TAIL = 10'h040,
      ST_QSTOP    = 10'h080,
      ST_COAST    = 10'h100,
      ST_LOCKOUT  = 10'h200
   } rcs_state_type;

   typedef struct packed {
      rcs_state_type st;
      logic          fwd_s1;
      logic          fwd_s2;
      logic          rev_s1;
      logic          rev_s2;
      logic          stop_n_s1;
      logic          stop_n_s2;
      logic          en_s1;
      logic          en_s2;
      logic [16:0]   tick_cnt;
      logic          tick;
      logic          fwd_lat;
      logic          rev_lat;
      logic [19:0]   timer;
      logic          dir_rev;
      logic          run_active;
      logic          out_block;
      logic          dwell_hold;
      logic [1:0]    ramp_sel;
      logic [15:0]   ramp_target;
      logic [19:0]   qstop_ms;
   } rcs_regs_type;

endpackage

// ==== logic/rcs_sequencer.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Three-wire terminal function latches momentary forward or reverse presses.
// - Three-wire: forward and reverse together stop the drive.
// - Terminal with function code 13 acts as the run-enable input.
// - Gating mode 0 ignores enable; mode 1 accepts runs only when enabled, if the enable terminal has function code 13.
// - With gating active, run requests are ignored while enable is inactive.
// - Stop mode 0 coast, 1 timed stop, 2 timed stop with resume.
// - Coast mode blocks the output as soon as enable drops.
// - Timed stop decelerates to zero, restarts only on a fresh run command.
// - Timed stop with resume restarts once enabled with run present.
// - Quick-stop time 0.0 to 600.0 s, default 5.0, timed modes only.
// - Dwell only in open-loop voltage-per-frequency control mode.
// - Start: ramp to acceleration dwell frequency, hold, then normal acceleration.
// - Stop: ramp to deceleration dwell frequency, hold, then decelerate to stop.
// - Dwell frequencies default 5.00 Hz, held between start and maximum.
// - Dwell times 0.0 to 60.0 s, default 0.0.
// - A dwell with zero time or zero frequency is skipped.
// - Only the first acceleration after a run command dwells.
// - Deceleration dwell only on stop, not on reference drop or external brake.
module rcs_sequencer #(
   parameter int unsigned MS_CYCLES = rcs_pkg::MS_CYCLES
) (
   // Clock and reset
   input  wire logic                CLK,
   input  wire logic                RST,
   // Terminal pins, asynchronous
   input  wire logic                FWD_IN,
   input  wire logic                REV_IN,
   input  wire logic                STOP_IN_N,
   input  wire logic                RUN_EN_IN,
   input  wire logic                EXT_BRAKE,
   // Parameters and ramp feedback
   input  wire rcs_pkg::rcs_cfg_type CFG,
   input  wire logic [15:0]         OUT_FREQ,
   // Sequencer outputs
   output logic                     RUN_ACTIVE,
   output logic                     OUT_BLOCK,
   output logic                     DIR_REV,
   output logic                     DWELL_HOLD,
   output logic [1:0]               RAMP_SEL,
   output logic [15:0]              RAMP_TARGET,
   output logic [19:0]              QSTOP_MS
);

   rcs_pkg::rcs_regs_type r;
   rcs_pkg::rcs_regs_type n;

   logic        three_wire;
   logic        both_cmds;
   logic        run_fwd;
   logic        run_rev;
   logic        run_cmd;
   logic        gated;
   logic        en_ok;
   logic        dwell_mode;
   logic        acc_dwell;
   logic        dec_dwell;
   logic [15:0] acc_freq;
   logic [15:0] dec_freq;
   logic [9:0]  acc_time;
   logic [9:0]  dec_time;
   logic        running;

   function automatic logic [15:0] clamp_freq(input logic [15:0] f,
                                              input logic [15:0] lo,
                                              input logic [15:0] hi);
      logic [15:0] v;
      v = f;
      if (f < lo) begin
         v = lo;
      end else if (f > hi) begin
         v = hi;
      end
      return v;
   endfunction

   function automatic logic [9:0] sat_time(input logic [9:0] t);
      return (t > rcs_pkg::DWELL_TIME_MAX) ? rcs_pkg::DWELL_TIME_MAX : t;
   endfunction

   always_comb begin
      n = r;
      // Pins other than EXT_BRAKE pass two flops before anything reads them
      n.fwd_s1    = FWD_IN;
      n.fwd_s2    = r.fwd_s1;
      n.rev_s1    = REV_IN;
      n.rev_s2    = r.rev_s1;
      n.stop_n_s1 = STOP_IN_N;
      n.stop_n_s2 = r.stop_n_s1;
      n.en_s1     = RUN_EN_IN;
      n.en_s2     = r.en_s1;

      n.tick = 1'b0;
      if (r.tick_cnt == 17'(MS_CYCLES - 1)) begin
         n.tick_cnt = rcs_pkg::TICK_CNT_RESET;
         n.tick     = 1'b1;
      end else begin
         n.tick_cnt = r.tick_cnt + 17'h00001;
      end

      three_wire = (CFG.input_terminal_function == rcs_pkg::FUNC_THREE_WIRE);
      both_cmds  = r.fwd_s2 && r.rev_s2;

      // Sampling on the tick accepts any press of at least one millisecond
      if (!three_wire || both_cmds || !r.stop_n_s2 || r.st == rcs_pkg::ST_LOCKOUT) begin
         n.fwd_lat = 1'b0;
         n.rev_lat = 1'b0;
      end else if (r.tick && r.fwd_s2) begin
         n.fwd_lat = 1'b1;
         n.rev_lat = 1'b0;
      end else if (r.tick && r.rev_s2) begin
         n.fwd_lat = 1'b0;
         n.rev_lat = 1'b1;
      end

      run_fwd = three_wire ? r.fwd_lat : (r.fwd_s2 && !r.rev_s2);
      run_rev = three_wire ? r.rev_lat : (r.rev_s2 && !r.fwd_s2);
      run_cmd = run_fwd || run_rev;

      gated = (CFG.gating_mode_param == rcs_pkg::GATING_BY_INPUT) &&
              (CFG.enable_terminal_function == rcs_pkg::FUNC_RUN_ENABLE);
      en_ok = !gated || r.en_s2;

      acc_freq   = clamp_freq(CFG.acc_dwell_freq, CFG.start_freq, CFG.max_freq);
      dec_freq   = clamp_freq(CFG.dec_dwell_freq, CFG.start_freq, CFG.max_freq);
      acc_time   = sat_time(CFG.acc_dwell_time);
      dec_time   = sat_time(CFG.dec_dwell_time);
      dwell_mode = (CFG.control_mode_param == rcs_pkg::CTRL_MODE_VF);
      acc_dwell  = dwell_mode && (acc_time != 10'h000) && (CFG.acc_dwell_freq != 16'h0000);
      dec_dwell  = dwell_mode && (dec_time != 10'h000) && (CFG.dec_dwell_freq != 16'h0000) &&
                   !EXT_BRAKE;

      running = (r.st != rcs_pkg::ST_IDLE) && (r.st != rcs_pkg::ST_COAST) &&
                (r.st != rcs_pkg::ST_LOCKOUT) && (r.st != rcs_pkg::ST_QSTOP);

      if (r.tick && r.timer != rcs_pkg::TIMER_RESET) begin
         n.timer = r.timer - 20'h00001;
      end

      case (r.st)
         rcs_pkg::ST_IDLE: begin
            if (run_cmd && en_ok) begin
               n.dir_rev = run_rev;
               if (acc_dwell) begin
                  n.st = rcs_pkg::ST_ACC_RAMP;
               end else begin
                  n.st = rcs_pkg::ST_RUN;
               end
            end
         end
         rcs_pkg::ST_ACC_RAMP: begin
            if (!run_cmd) begin
               n.st = rcs_pkg::ST_DEC_TAIL;
            end else if (OUT_FREQ >= acc_freq) begin
               n.st    = rcs_pkg::ST_ACC_HOLD;
               n.timer = 20'(acc_time) * 20'(rcs_pkg::MS_PER_TENTH);
            end
         end
         rcs_pkg::ST_ACC_HOLD: begin
            if (!run_cmd) begin
               n.st = rcs_pkg::ST_DEC_TAIL;
            end else if (r.timer == rcs_pkg::TIMER_RESET ||
                         (r.tick && r.timer == 20'h00001)) begin
               n.st = rcs_pkg::ST_RUN;
            end
         end
         rcs_pkg::ST_RUN: begin
            // A lower reference just follows the ramp; only a stop dwells
            if (!run_cmd) begin
               if (dec_dwell && OUT_FREQ > dec_freq) begin
                  n.st = rcs_pkg::ST_DEC_RAMP;
               end else begin
                  n.st = rcs_pkg::ST_DEC_TAIL;
               end
            end
         end
         rcs_pkg::ST_DEC_RAMP: begin
            if (run_cmd) begin
               n.st = rcs_pkg::ST_RUN;
            end else if (EXT_BRAKE) begin
               n.st = rcs_pkg::ST_DEC_TAIL;
            end else if (OUT_FREQ <= dec_freq) begin
               n.st    = rcs_pkg::ST_DEC_HOLD;
               n.timer = 20'(dec_time) * 20'(rcs_pkg::MS_PER_TENTH);
            end
         end
         rcs_pkg::ST_DEC_HOLD: begin
            if (run_cmd) begin
               n.st = rcs_pkg::ST_RUN;
            end else if (r.timer == rcs_pkg::TIMER_RESET ||
                         (r.tick && r.timer == 20'h00001)) begin
               n.st = rcs_pkg::ST_DEC_TAIL;
            end
         end
         rcs_pkg::ST_DEC_TAIL: begin
            if (run_cmd) begin
               n.st = rcs_pkg::ST_RUN;
            end else if (OUT_FREQ == 16'h0000) begin
               n.st = rcs_pkg::ST_IDLE;
            end
         end
         rcs_pkg::ST_QSTOP: begin
            if (OUT_FREQ == 16'h0000) begin
               if (CFG.stop_mode_param == rcs_pkg::STOP_TIMED_RESUME) begin
                  n.st = rcs_pkg::ST_IDLE;
               end else begin
                  n.st = rcs_pkg::ST_LOCKOUT;
               end
            end
         end
         rcs_pkg::ST_COAST: begin
            if (en_ok) begin
               n.st = rcs_pkg::ST_IDLE;
            end
         end
         rcs_pkg::ST_LOCKOUT: begin
            // Waits for the run command to drop so a fresh one is needed
            if (!run_cmd) begin
               n.st = rcs_pkg::ST_IDLE;
            end
         end
         default: begin
            n.st = rcs_pkg::ST_IDLE;
         end
      endcase

      // Enable loss overrides any running state
      if (running && !en_ok) begin
         if (CFG.stop_mode_param == rcs_pkg::STOP_COAST) begin
            n.st = rcs_pkg::ST_COAST;
         end else begin
            n.st = rcs_pkg::ST_QSTOP;
         end
      end

      n.out_block  = (n.st == rcs_pkg::ST_IDLE) || (n.st == rcs_pkg::ST_COAST) ||
                     (n.st == rcs_pkg::ST_LOCKOUT);
      n.run_active = !n.out_block;
      n.dwell_hold = (n.st == rcs_pkg::ST_ACC_HOLD) || (n.st == rcs_pkg::ST_DEC_HOLD);
      case (n.st)
         rcs_pkg::ST_ACC_RAMP, rcs_pkg::ST_ACC_HOLD: begin
            n.ramp_sel    = rcs_pkg::RAMP_ACC;
            n.ramp_target = acc_freq;
         end
         rcs_pkg::ST_RUN: begin
            n.ramp_sel    = (OUT_FREQ > CFG.target_freq) ? rcs_pkg::RAMP_DEC : rcs_pkg::RAMP_ACC;
            n.ramp_target = CFG.target_freq;
         end
         rcs_pkg::ST_DEC_RAMP, rcs_pkg::ST_DEC_HOLD: begin
            n.ramp_sel    = rcs_pkg::RAMP_DEC;
            n.ramp_target = dec_freq;
         end
         rcs_pkg::ST_QSTOP: begin
            n.ramp_sel    = rcs_pkg::RAMP_QSTOP;
            n.ramp_target = 16'h0000;
         end
         default: begin
            n.ramp_sel    = rcs_pkg::RAMP_DEC;
            n.ramp_target = 16'h0000;
         end
      endcase

      // Quick-stop time only matters in the timed modes
      if (CFG.stop_mode_param == rcs_pkg::STOP_COAST) begin
         n.qstop_ms = rcs_pkg::TIMER_RESET;
      end else if (CFG.decel_time_param > rcs_pkg::QSTOP_TIME_MAX) begin
         n.qstop_ms = 20'(rcs_pkg::QSTOP_TIME_MAX) * 20'(rcs_pkg::MS_PER_TENTH);
      end else begin
         n.qstop_ms = 20'(CFG.decel_time_param) * 20'(rcs_pkg::MS_PER_TENTH);
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         r             <= '0;
         r.st          <= rcs_pkg::ST_IDLE;
         r.stop_n_s1   <= 1'b1;
         r.stop_n_s2   <= 1'b1;
         r.tick_cnt    <= rcs_pkg::TICK_CNT_RESET;
         r.timer       <= rcs_pkg::TIMER_RESET;
         r.out_block   <= 1'b1;
         r.ramp_sel    <= rcs_pkg::RAMP_DEC;
         r.qstop_ms    <= rcs_pkg::TIMER_RESET;
      end else begin
         r <= n;
      end
   end

   assign RUN_ACTIVE  = r.run_active;
   assign OUT_BLOCK   = r.out_block;
   assign DIR_REV     = r.dir_rev;
   assign DWELL_HOLD  = r.dwell_hold;
   assign RAMP_SEL    = r.ramp_sel;
   assign RAMP_TARGET = r.ramp_target;
   assign QSTOP_MS    = r.qstop_ms;

   AST_LATCH_HOLDS: assert property (@(posedge CLK) disable iff (RST)
      three_wire && r.fwd_lat && r.stop_n_s2 && !r.rev_s2 && r.st != rcs_pkg::ST_LOCKOUT
      |=> r.fwd_lat)
      else $error("forward latch lost without a stop");

   AST_PULSE_QUALIFY: assert property (@(posedge CLK) disable iff (RST)
      three_wire && r.tick && r.fwd_s2 && !r.rev_s2 && r.stop_n_s2 &&
      r.st != rcs_pkg::ST_LOCKOUT |=> r.fwd_lat)
      else $error("qualified forward press not latched");

   AST_BOTH_STOP: assert property (@(posedge CLK) disable iff (RST)
      three_wire && both_cmds |=> !r.fwd_lat && !r.rev_lat)
      else $error("both commands did not clear the latches");

   AST_GATED_IDLE: assert property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_IDLE && gated && !r.en_s2 |=> r.st == rcs_pkg::ST_IDLE)
      else $error("started while enable inactive");

   AST_COAST_BLOCK: assert property (@(posedge CLK) disable iff (RST)
      running && !en_ok && CFG.stop_mode_param == rcs_pkg::STOP_COAST
      |=> r.st == rcs_pkg::ST_COAST && OUT_BLOCK)
      else $error("coast stop did not block output");

   AST_QSTOP_LOCK: assert property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_QSTOP && OUT_FREQ == 16'h0000 &&
      CFG.stop_mode_param == rcs_pkg::STOP_TIMED |=> r.st == rcs_pkg::ST_LOCKOUT)
      else $error("timed stop did not lock out");

   AST_QSTOP_RESUME: assert property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_QSTOP && OUT_FREQ == 16'h0000 &&
      CFG.stop_mode_param == rcs_pkg::STOP_TIMED_RESUME |=> r.st == rcs_pkg::ST_IDLE)
      else $error("resume mode did not return to idle");

   AST_QSTOP_TIME: assert property (@(posedge CLK) disable iff (RST)
      CFG.stop_mode_param == rcs_pkg::STOP_COAST |=> QSTOP_MS == 20'h00000)
      else $error("quick-stop time set in coast mode");

   AST_NO_DWELL_MODE: assert property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_IDLE && !dwell_mode |=> r.st != rcs_pkg::ST_ACC_RAMP)
      else $error("dwell outside voltage-per-frequency mode");

   AST_ACC_HOLD_END: assert property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_ACC_HOLD && run_cmd && en_ok && r.tick && r.timer == 20'h00001
      |=> r.st == rcs_pkg::ST_RUN ##1 !DWELL_HOLD)
      else $error("acceleration hold did not end on time");

   AST_DEC_HOLD_END: assert property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_DEC_HOLD && !run_cmd && en_ok && r.tick && r.timer == 20'h00001
      |=> r.st == rcs_pkg::ST_DEC_TAIL)
      else $error("deceleration hold did not end on time");

   AST_REACC_NO_DWELL: assert property (@(posedge CLK) disable iff (RST)
      (r.st == rcs_pkg::ST_DEC_TAIL || r.st == rcs_pkg::ST_DEC_HOLD) && run_cmd && en_ok
      |=> r.st == rcs_pkg::ST_RUN)
      else $error("re-acceleration dwelled again");

   COV_ACC_DWELL: cover property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_ACC_HOLD ##1 r.st == rcs_pkg::ST_RUN);
   COV_DEC_DWELL: cover property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_DEC_HOLD ##1 r.st == rcs_pkg::ST_DEC_TAIL);
   COV_QSTOP: cover property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_QSTOP ##1 r.st == rcs_pkg::ST_LOCKOUT);
   COV_COAST: cover property (@(posedge CLK) disable iff (RST)
      r.st == rcs_pkg::ST_COAST);

endmodule // rcs_sequencer

// ==== testbench/rcs_terminal_model.sv ====
`timescale 1ns/1ps
module rcs_terminal_model #(
   parameter int unsigned MS_CYCLES = 10
) (
   // Clock
   input  wire logic CLK,
   // Terminal pins
   output logic      FWD_IN,
   output logic      REV_IN,
   output logic      STOP_IN_N,
   output logic      RUN_EN_IN
);
   initial begin
      FWD_IN    = 1'b0;
      REV_IN    = 1'b0;
      STOP_IN_N = 1'b1;
      RUN_EN_IN = 1'b0;
   end

   // Maintained switches or controller outputs
   task automatic set_pins(input logic fwd, input logic rev, input logic en);
      @(posedge CLK);
      FWD_IN    <= fwd;
      REV_IN    <= rev;
      RUN_EN_IN <= en;
   endtask

   // Momentary press: 0 fwd, 1 rev, 2 both, 3 stop button
   task automatic press(input logic [1:0] which);
      @(posedge CLK);
      FWD_IN    <= (which == 2'h0) || (which == 2'h2);
      REV_IN    <= (which == 2'h1) || (which == 2'h2);
      STOP_IN_N <= (which != 2'h3);
      // Two ticks long, so a tick always lands inside the press whatever its phase
      repeat (2 * MS_CYCLES) @(posedge CLK);
      FWD_IN    <= 1'b0;
      REV_IN    <= 1'b0;
      STOP_IN_N <= 1'b1;
   endtask
endmodule // rcs_terminal_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
   localparam int unsigned MS  = 10;
   localparam logic [15:0] TGT = 16'h07D0;
   logic                 clk, rst, ext_brake, saw_hold;
   logic                 fwd_in, rev_in, stop_in_n, run_en_in;
   logic                 run_active, out_block, dir_rev, dwell_hold;
   logic [1:0]           ramp_sel;
   logic [15:0]          ramp_target, out_freq;
   logic [19:0]          qstop_ms;
   rcs_pkg::rcs_cfg_type cfg, c;
   int                   errors, samples_checked, cycles, n;

   rcs_sequencer #(.MS_CYCLES(MS)) dut_u (.CLK(clk), .RST(rst), .FWD_IN(fwd_in),
      .REV_IN(rev_in), .STOP_IN_N(stop_in_n), .RUN_EN_IN(run_en_in), .EXT_BRAKE(ext_brake),
      .CFG(cfg), .OUT_FREQ(out_freq), .RUN_ACTIVE(run_active), .OUT_BLOCK(out_block),
      .DIR_REV(dir_rev), .DWELL_HOLD(dwell_hold), .RAMP_SEL(ramp_sel),
      .RAMP_TARGET(ramp_target), .QSTOP_MS(qstop_ms));
   rcs_terminal_model #(.MS_CYCLES(MS)) term_u (.CLK(clk), .FWD_IN(fwd_in),
      .REV_IN(rev_in), .STOP_IN_N(stop_in_n), .RUN_EN_IN(run_en_in));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Crude ramp generator: fixed step toward the target, frozen on a plateau
   always @(posedge clk) begin
      if (rst || out_block) begin
         out_freq <= 16'h0000;
      end else if (!dwell_hold && out_freq < ramp_target) begin
         out_freq <= (ramp_target - out_freq > 16'h0064) ? out_freq + 16'h0064 : ramp_target;
      end else if (!dwell_hold && out_freq > ramp_target) begin
         out_freq <= (out_freq - ramp_target > 16'h0064) ? out_freq - 16'h0064 : ramp_target;
      end
      if (dwell_hold === 1'b1) begin
         saw_hold <= 1'b1;
      end
      cycles++;
      if (cycles == 60000) begin
         errors++;
         summarize();
      end
   end

   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return out_block;
         1: return dwell_hold;
         default: return out_freq === TGT;
      endcase
   endfunction

   // Bounded wait; cnt tells how many cycles it took
   task automatic wait_for(input int sel, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         #1;
         cnt++;
      end while (sig(sel) !== lvl && cnt < lim);
   endtask

   task automatic use_cfg(input rcs_pkg::rcs_cfg_type v, input logic brake);
      @(posedge clk);
      cfg       <= v;
      ext_brake <= brake;
   endtask

   function automatic rcs_pkg::rcs_cfg_type base_cfg();
      rcs_pkg::rcs_cfg_type r;
      r = '0;
      r.enable_terminal_function = rcs_pkg::FUNC_RUN_ENABLE;
      r.acc_dwell_freq           = rcs_pkg::DWELL_FREQ_DEFAULT;
      r.dec_dwell_freq           = rcs_pkg::DWELL_FREQ_DEFAULT;
      r.acc_dwell_time           = rcs_pkg::DWELL_TIME_DEFAULT;
      r.dec_dwell_time           = rcs_pkg::DWELL_TIME_DEFAULT;
      r.decel_time_param         = rcs_pkg::QSTOP_TIME_DEFAULT;
      r.start_freq               = 16'h00C8;
      r.max_freq                 = 16'h1770;
      r.target_freq              = TGT;
      return r;
   endfunction

   initial begin
      errors = 0;
      samples_checked = 0;
      cycles = 0;
      saw_hold = 1'b0;
      rst = 1'b1;
      ext_brake = 1'b0;
      cfg = base_cfg();
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Dwell table: 0 none, 1 both, 2 wrong control mode, 3 brake on stop, 4 zero frequency
      for (int i = 0; i < 5; i++) begin
         c = base_cfg();
         c.acc_dwell_time = (i == 1 || i == 2 || i == 4) ? 10'h001 : 10'h000;
         c.dec_dwell_time = (i >= 1 && i <= 3) ? 10'h001 : 10'h000;
         c.acc_dwell_freq = (i == 4) ? 16'h0000 : 16'h0064;
         c.control_mode_param = (i == 2) ? 3'h1 : rcs_pkg::CTRL_MODE_VF;
         use_cfg(c, i == 3);
         saw_hold = 1'b0;
         term_u.set_pins(!i[0], i[0], 1'b0);
         wait_for(0, 1'b0, 50, n);
         check(20'(dir_rev), 20'(i[0]));
         if (i == 1) begin
            wait_for(1, 1'b1, 100, n);
            check(20'(ramp_target), 20'(c.start_freq));
            wait_for(1, 1'b0, 1100, n);
            check(20'(n > 985 && n < 1015), 20'h1);
         end
         wait_for(2, 1'b1, 200, n);
         check(20'(ramp_target), 20'(TGT));
         check(20'(ramp_sel), 20'(rcs_pkg::RAMP_ACC));
         check(20'(saw_hold), 20'(i == 1));
         saw_hold = 1'b0;
         term_u.set_pins(1'b0, 1'b0, 1'b0);
         if (i == 1) begin
            wait_for(1, 1'b1, 100, n);
            check(20'(ramp_target), 20'(c.dec_dwell_freq));
            check(20'(ramp_sel), 20'(rcs_pkg::RAMP_DEC));
            term_u.set_pins(1'b0, 1'b1, 1'b0);
            wait_for(1, 1'b0, 20, n);
            saw_hold = 1'b0;
            wait_for(2, 1'b1, 200, n);
            check(20'(saw_hold), 20'h0);
            term_u.set_pins(1'b0, 1'b0, 1'b0);
         end
         wait_for(0, 1'b1, 1500, n);
         check(20'(out_block), 20'h1);
         check(20'(saw_hold), 20'(i == 1));
      end
      // Gating needs the enable function code on the terminal
      c = base_cfg();
      c.gating_mode_param = rcs_pkg::GATING_BY_INPUT;
      c.enable_terminal_function = 8'h0C;
      use_cfg(c, 1'b0);
      term_u.set_pins(1'b1, 1'b0, 1'b0);
      wait_for(0, 1'b0, 50, n);
      check(20'(out_block), 20'h0);
      term_u.set_pins(1'b0, 1'b0, 1'b0);
      wait_for(0, 1'b1, 300, n);
      c.enable_terminal_function = rcs_pkg::FUNC_RUN_ENABLE;
      for (int m = 0; m < 3; m++) begin
         c.stop_mode_param = 2'(m);
         use_cfg(c, 1'b0);
         term_u.set_pins(1'b1, 1'b0, 1'b0);
         repeat (30) @(posedge clk);
         check(20'(out_block), 20'h1);
         term_u.set_pins(1'b1, 1'b0, 1'b1);
         wait_for(0, 1'b0, 50, n);
         check(20'(run_active), 20'h1);
         wait_for(2, 1'b1, 200, n);
         term_u.set_pins(1'b1, 1'b0, 1'b0);
         if (m == 0) begin
            wait_for(0, 1'b1, 6, n);
            check(20'(out_block), 20'h1);
         end else begin
            repeat (6) @(posedge clk);
            check(20'(ramp_sel), 20'(rcs_pkg::RAMP_QSTOP));
            check(qstop_ms, 20'h01388);
            wait_for(0, 1'b1, 300, n);
         end
         term_u.set_pins(1'b1, 1'b0, 1'b1);
         repeat (30) @(posedge clk);
         check(20'(out_block), 20'(m == 1));
         if (m == 1) begin
            term_u.set_pins(1'b0, 1'b0, 1'b1);
            repeat (10) @(posedge clk);
            term_u.set_pins(1'b1, 1'b0, 1'b1);
            wait_for(0, 1'b0, 50, n);
            check(20'(out_block), 20'h0);
         end
         term_u.set_pins(1'b0, 1'b0, 1'b1);
         wait_for(0, 1'b1, 300, n);
      end
      // Three-wire presses
      c = base_cfg();
      c.input_terminal_function = rcs_pkg::FUNC_THREE_WIRE;
      use_cfg(c, 1'b0);
      term_u.press(2'h0);
      repeat (30) @(posedge clk);
      check(20'(run_active), 20'h1);
      term_u.press(2'h3);
      wait_for(0, 1'b1, 300, n);
      check(20'(out_block), 20'h1);
      term_u.press(2'h1);
      repeat (30) @(posedge clk);
      check(20'(dir_rev), 20'h1);
      term_u.press(2'h2);
      wait_for(0, 1'b1, 300, n);
      repeat (30) @(posedge clk);
      check(20'(out_block), 20'h1);
      summarize();
   end
endmodule // tb
